// File: hw/drc_map.svh
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH
// register word offsets and byte addresses on the apb word grid
`define DRC_CONTROL_OFFSET 12'h000
`define DRC_SAMPLE_OFFSET 12'h002
`define DRC_CONTROL_ADDR 12'h000
`define DRC_SAMPLE_ADDR 12'h008
`define DRC_SLEEP_ADDR 12'h00c
// control field positions
`define DRC_CTRL_ENABLE_BIT 0
`define DRC_CTRL_BUFFER_BIT 6
`define DRC_CTRL_STANDBY_BIT 7
`define DRC_CTRL_WMASK 8'hc1
`define DRC_CONTROL_RESET 8'h00
`define DRC_CODE_RESET 10'h000
`define DRC_LOW_RESET 2'h0
`endif

// File: hw/drc_pkg.sv
package drc_pkg;
    // sleep mode request from the power manager
    typedef enum logic [1:0] {DRC_SLEEP_NONE, DRC_SLEEP_IDLE, DRC_SLEEP_STANDBY,
                              DRC_SLEEP_POWERDOWN} drc_sleep_t;
    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } drc_apb_req_t;
    // drive bundle to the analog core
    typedef struct packed {
        logic conv_on;
        logic buffer_on;
        logic load;
        logic [9:0] code;
    } drc_analog_t;
endpackage

// File: hw/drc_top.sv
`timescale 1ns/100ps
`include "drc_map.svh"
// Functional notes
// - control at 0x00, resets to zero
// - run_in_standby keeps converter alive in standby
// - bit 6 turns output buffer on
// - bit 0 enables converter
// - ten-bit sample at 0x02, reset zero
// - high byte holds sample bits 9:2
// - low byte holds sample bits 1:0
// - code left-aligned at bits 15:6
// - output updates only on high-byte write
// - enabled: conversion starts on high-byte write
// - disabled: conversion waits for enable
// - power-down always off; standby off unless kept
module drc_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire drc_pkg::drc_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power manager
    input wire drc_pkg::drc_sleep_t sleep_mode,
    // analog core
    output drc_pkg::drc_analog_t analog
);
    import drc_pkg::*;

    logic [7:0] control_reg;
    logic [1:0] low_stage_reg;
    logic [9:0] code_reg;
    logic pending_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    drc_analog_t analog_reg;
    drc_analog_t analog_next;
    logic [1:0] sleep_meta_reg;
    logic [1:0] sleep_sync_reg;
    logic setup;
    logic wr_ctrl;
    logic wr_sample;
    logic wr_low;
    logic wr_high;
    logic mapped;
    logic conv_run;
    logic [31:0] rd_value;

    // sleep request comes from another block's timing, so synchronise it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sleep_meta_reg <= 2'h0;
            sleep_sync_reg <= 2'h0;
        end
        else
        begin
            sleep_meta_reg <= sleep_mode;
            sleep_sync_reg <= sleep_meta_reg;
        end
    end

    // zero-wait slave: answer in the first access cycle
    // a write lands only at the edge where the access phase meets pready
    assign setup = apb_req.psel && apb_req.penable && pready_reg;
    assign mapped = (apb_req.paddr == `DRC_CONTROL_ADDR) ||
                    (apb_req.paddr == `DRC_SAMPLE_ADDR);
    assign wr_ctrl = setup && apb_req.pwrite && (apb_req.paddr == `DRC_CONTROL_ADDR)
                     && apb_req.pstrb[0];
    assign wr_sample = setup && apb_req.pwrite && (apb_req.paddr == `DRC_SAMPLE_ADDR);
    assign wr_low = wr_sample && apb_req.pstrb[0];
    assign wr_high = wr_sample && apb_req.pstrb[1];

    // control register; only bits 7, 6 and 0 exist
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_reg <= `DRC_CONTROL_RESET;
        else if (wr_ctrl)
            control_reg <= apb_req.pwdata[7:0] & `DRC_CTRL_WMASK;
    end

    // low bits are staged so the analog code never shows a half update
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_stage_reg <= `DRC_LOW_RESET;
        else if (wr_low)
            low_stage_reg <= apb_req.pwdata[7:6];
    end

    // committed code; a same-cycle low and high write commits both new values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            code_reg <= `DRC_CODE_RESET;
        else if (wr_high)
            code_reg <= {apb_req.pwdata[15:8],
                         wr_low ? apb_req.pwdata[7:6] : low_stage_reg};
    end

    // conversion waiting for the enable; a write while running loads at once,
    // so it must not also leave a pending start behind (no double load pulse)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pending_reg <= 1'b0;
        else if (wr_high && !conv_run)
            pending_reg <= 1'b1;
        else if (conv_run)
            pending_reg <= 1'b0;
    end

    // converter runs when enabled unless sleep gates it
    always_comb
    begin
        conv_run = control_reg[`DRC_CTRL_ENABLE_BIT];
        if (sleep_sync_reg == DRC_SLEEP_POWERDOWN)
            conv_run = 1'b0;
        else if (sleep_sync_reg == DRC_SLEEP_STANDBY && !control_reg[`DRC_CTRL_STANDBY_BIT])
            conv_run = 1'b0;
        analog_next.conv_on = conv_run;
        analog_next.buffer_on = conv_run && control_reg[`DRC_CTRL_BUFFER_BIT];
        analog_next.load = conv_run && (pending_reg || wr_high);
        analog_next.code = wr_high ? {apb_req.pwdata[15:8],
                           wr_low ? apb_req.pwdata[7:6] : low_stage_reg} : code_reg;
    end

    // analog drive registered so outputs come straight from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            analog_reg <= '0;
        else
            analog_reg <= analog_next;
    end
    assign analog = analog_reg;

    // read mux; sample view is left-aligned with low six bits zero
    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (apb_req.paddr == `DRC_CONTROL_ADDR)
            rd_value = {24'h000000, control_reg};
        else if (apb_req.paddr == `DRC_SAMPLE_ADDR)
            rd_value = {16'h0000, code_reg[9:2], low_stage_reg, 6'h00};
    end

    // apb answer: unmapped addresses give pslverr and zero data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= apb_req.psel && !pready_reg && !apb_req.penable;
            prdata_reg <= (apb_req.psel && !apb_req.pwrite) ? rd_value : 32'h0000_0000;
            pslverr_reg <= apb_req.psel && !apb_req.penable && !mapped;
        end
    end
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

endmodule // drc_top

// File: verification/drc_checker.sv
`timescale 1ns/100ps
module drc_checker (
    // watched top-level ports
    input wire logic pclk,
    input wire logic presetn,
    input wire drc_pkg::drc_apb_req_t apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire drc_pkg::drc_sleep_t sleep_mode,
    input wire drc_pkg::drc_analog_t analog
);
    import drc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed writes and the fields they carry
    wire wr = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
    wire cw = wr & apb_req.paddr == 12'h000 & apb_req.pstrb[0];
    wire sw = wr & apb_req.paddr == 12'h008;
    wire [9:0] cv = {apb_req.pwdata[15:8], apb_req.pwdata[7:6]};
    wire [1:0] cb2 = {apb_req.pwdata[6] & apb_req.pwdata[0], apb_req.pwdata[0]};
    ready_a: assert property (apb_req.psel & !apb_req.penable |=> pready) else $error("no ready");
    rst_zero_a:
        assert property ($rose(presetn) |-> analog == '0) else $error("reset out");
    err_data_a: assert property (pslverr |-> prdata == 0) else $error("err data");
    ctrl_drive_a:
        assert property ((sleep_mode == DRC_SLEEP_NONE) [*4] ##0 cw
            |=> ##1 {analog.buffer_on, analog.conv_on} == $past(cb2, 2)) else $error("ctrl out");
    low_hold_a:
        assert property (sw & apb_req.pstrb[1:0] == 2'b01 |=> $stable(analog.code)) else $error("low");
    high_commit_a:
        assert property (analog.conv_on & sw & apb_req.pstrb[1:0] == 2'b11
            |=> analog.load & analog.code == $past(cv)) else $error("commit");
    pdown_off_a:
        assert property ((sleep_mode == DRC_SLEEP_POWERDOWN) [*4]
            |-> !analog.conv_on & !analog.buffer_on) else $error("pdown");
    unused_zero_a:
        assert property (pready & !apb_req.pwrite & apb_req.paddr == 12'h000
            |-> prdata[31:8] == 0 & prdata[5:1] == 0) else $error("unused");
endmodule // drc_checker
bind drc_top drc_checker chk (.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr,
    .sleep_mode, .analog);

// File: verification/drc_top_test.sv
`timescale 1ns/100ps
module drc_top_test;
    import drc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    drc_apb_req_t apb_req = '0;
    drc_sleep_t sleep_mode = DRC_SLEEP_NONE;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    drc_analog_t analog;
    logic [31:0] rd;
    int error_cnt = 0;
    int cmp_count = 0;
    int n;
    drc_top dut (.pclk, .presetn, .apb_req, .prdata, .pready, .pslverr, .sleep_mode, .analog);
    initial forever #4 pclk = ~pclk;
    task close_out();
        $display("errors %0d of %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(string s, logic [31:0] g, logic [31:0] e);
        cmp_count++;
        if (g !== e)
            $display("MISMATCH %s exp %h got %h", s, e, g);
        error_cnt += int'(g !== e);
    endtask
    // request held until pready is sampled; the error flag is folded into rd bit 31
    task apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
        apb_req <= '{1'b1, 1'b0, w, a, d, s};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        #1;
        for (n = 0; n < 9 && pready !== 1'b1; n++)
        begin
            @(posedge pclk);
            #1;
        end
        chk("ready", pready, 1);
        if (pready !== 1'b1)
            close_out();
        rd = prdata | {pslverr, 31'h0};
        // the edge that samples pready high completes the transfer
        @(posedge pclk);
    endtask
    task idle(int c);
        apb_req <= '0;
        repeat (c) @(posedge pclk);
    endtask
    task t_reg();
        apb(0, 12'h000, 0, 0);
        chk("ctrl", rd, 0);
        apb(1, 12'h000, 32'hff, 4'h1);
        apb(0, 12'h000, 0, 0);
        chk("mask", rd, 32'hc1);
        apb(0, 12'h004, 0, 0);
        chk("unmapped", rd, 32'h80000000);
        idle(2);
        chk("drive", {analog.conv_on, analog.buffer_on}, 2'b11);
    endtask
    // low lane only stages; the high lane commits both parts
    task t_data();
        apb(1, 12'h008, 32'hff, 4'h1);
        apb(0, 12'h008, 0, 0);
        chk("stage", rd, 32'hc0);
        chk("hold", analog.code, 0);
        apb(1, 12'h008, 32'ha500, 4'h2);
        idle(1);
        chk("load", {analog.load, analog.code}, {1'b1, 10'h297});
        apb(1, 12'h008, 32'h5a80, 4'h3);
    endtask
    task t_pend();
        apb(1, 12'h000, 0, 4'h1);
        apb(1, 12'h008, 32'h1240, 4'h3);
        idle(3);
        chk("idle", analog.load, 0);
        apb(1, 12'h000, 1, 4'h1);
        idle(0);
        for (n = 0; n < 8 && analog.load !== 1'b1; n++)
            @(posedge pclk);
        chk("late", {analog.load, analog.code}, {1'b1, 10'h049});
    endtask
    task t_sleep();
        apb(1, 12'h000, 32'h41, 4'h1);
        sleep_mode <= DRC_SLEEP_STANDBY;
        idle(5);
        chk("stby", {analog.conv_on, analog.buffer_on}, 0);
        apb(1, 12'h000, 32'hc1, 4'h1);
        idle(5);
        chk("kept", {analog.conv_on, analog.buffer_on}, 2'b11);
        sleep_mode <= DRC_SLEEP_POWERDOWN;
        idle(5);
        chk("pdown", analog.conv_on, 0);
    endtask
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reg();
        t_data();
        t_pend();
        t_sleep();
        close_out();
    end
endmodule // drc_top_test
